// ===== rtl/pcsd_clock_ctrl.sv
// How it works
// - PWM pairs 2/3 and 0/1: crystal, 32k, bus clock, 22M oscillator.
// - CAN source: crystal, PLL, or 22M oscillator for either 1x code.
// - Serial port source: crystal, PLL, or 22M oscillator for 1x.
// - Timers: crystal, 32k, bus clock, external trigger, 1xx oscillator.
// - Converter source: crystal, PLL, or 22M oscillator for 1x.
// - Watchdog source: crystal or 10k oscillator; write-protected field.
// - PWM pairs 6/7 and 4/5 choose among the same four sources.
// - Frequency divider source: crystal, 32k, bus clock, 22M oscillator.
// - Audio serial source: crystal, PLL, bus clock, 22M oscillator.
// - Core bus clock is its source divided by field plus one.
// - USB clock is PLL output divided by field plus one.
// - Serial port clock is its source divided by field plus one.
// - Converter clock is its source divided by eight-bit field plus one.
// - CAN clock divides by sixteen times high part plus low part, plus one.
// - PLL reference is 22M oscillator when set, crystal when clear.
// - PLL output gate bit set holds the PLL output low.
// - Bypass makes the PLL output equal its reference clock.
// - PLL powers down on its own bit or on system power-down.
// - Input ratio is field plus two; feedback ratio is field plus two.
// - Output divider codes map to ratios 1, 2, 2 and 4.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pcsd_defs.svh"

module pcsd_clock_ctrl
    import pcsd_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [`PCSD_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic write_protect_unlocked,
    input wire logic system_power_down_enable,
    input wire logic xtal_main_tick,
    input wire logic xtal_32k_tick,
    input wire logic osc_22m_tick,
    input wire logic osc_10k_tick,
    input wire logic hclk_source_tick,
    input wire logic pll_core_tick,
    input wire logic [3:0] timer_ext_trigger,
    output logic hclk_tick,
    output logic usb_tick,
    output logic uart_engine_tick,
    output logic adc_engine_tick,
    output logic can_engine_tick,
    output logic [3:0] pwm_pair_engine_tick,
    output logic [3:0] timer_engine_tick,
    output logic watchdog_engine_tick,
    output logic freq_divider_engine_tick,
    output logic audio_serial_engine_tick,
    output logic pll_ref_tick,
    output logic pll_out_tick,
    output logic pll_power_down,
    output logic pll_bypass,
    output logic [5:0] input_divide_ratio,
    output logic [9:0] feedback_divide_ratio,
    output logic [2:0] pll_output_ratio
);

    pcsd_word_t peripheral_clock_source_select_a;
    pcsd_word_t clock_divide_numbers;
    pcsd_word_t peripheral_clock_source_select_b;
    pcsd_word_t pll_control;

    logic wr_sel_a;
    logic wr_div;
    logic wr_sel_b;
    logic wr_pll;

    // Merge only writable bits; fixed bits keep their reset value
    function automatic pcsd_word_t merge(input pcsd_word_t old_val,
                                         input pcsd_word_t new_val,
                                         input pcsd_word_t mask);
        merge = (new_val & mask) | (old_val & ~mask);
    endfunction

    function automatic logic [2:0] out_ratio(input logic [1:0] code);
        unique case (code)
            2'h0: out_ratio = 3'h1;
            2'h1: out_ratio = 3'h2;
            2'h2: out_ratio = 3'h2;
            2'h3: out_ratio = 3'h4;
        endcase
    endfunction

    assign wr_sel_a = reg_wr && (reg_addr == `PCSD_OFF_SEL_A);
    assign wr_div = reg_wr && (reg_addr == `PCSD_OFF_DIV);
    assign wr_sel_b = reg_wr && (reg_addr == `PCSD_OFF_SEL_B);
    assign wr_pll = reg_wr && (reg_addr == `PCSD_OFF_PLL);

    always_ff @(posedge clk) begin
        if (reset) begin
            peripheral_clock_source_select_a <= `PCSD_RST_SEL_A;
        end else if (wr_sel_a) begin
            // Watchdog bits change only while protection is unlocked
            if (write_protect_unlocked) begin
                peripheral_clock_source_select_a <= merge(
                    peripheral_clock_source_select_a, reg_wdata,
                    `PCSD_WMASK_SEL_A | `PCSD_WMASK_WDT);
            end else begin
                peripheral_clock_source_select_a <= merge(
                    peripheral_clock_source_select_a, reg_wdata,
                    `PCSD_WMASK_SEL_A);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            clock_divide_numbers <= `PCSD_RST_DIV;
        end else if (wr_div) begin
            clock_divide_numbers <= merge(clock_divide_numbers, reg_wdata,
                                          `PCSD_WMASK_DIV);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            peripheral_clock_source_select_b <= `PCSD_RST_SEL_B;
        end else if (wr_sel_b) begin
            peripheral_clock_source_select_b <= merge(
                peripheral_clock_source_select_b, reg_wdata,
                `PCSD_WMASK_SEL_B);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pll_control <= `PCSD_RST_PLL;
        end else if (wr_pll) begin
            pll_control <= merge(pll_control, reg_wdata, `PCSD_WMASK_PLL);
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `PCSD_OFF_SEL_A: reg_rdata <= peripheral_clock_source_select_a;
                `PCSD_OFF_DIV: reg_rdata <= clock_divide_numbers;
                `PCSD_OFF_SEL_B: reg_rdata <= peripheral_clock_source_select_b;
                `PCSD_OFF_PLL: reg_rdata <= pll_control;
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // PLL control outputs
    logic ref_sel;
    logic gate_low;
    logic [4:0] in_field;
    logic [8:0] fb_field;

    assign ref_sel = pll_control[`PCSD_PLL_REFERENCE_SELECT_BIT];
    assign gate_low = pll_control[`PCSD_PLL_OE_BIT];
    assign in_field = pll_control[`PCSD_PLL_IN_LSB +: 5];
    assign fb_field = pll_control[`PCSD_PLL_FB_LSB +: 9];

    always_ff @(posedge clk) begin
        if (reset) begin
            pll_ref_tick <= 1'b0;
            pll_power_down <= 1'b1;
            pll_bypass <= 1'b0;
            input_divide_ratio <= '0;
            feedback_divide_ratio <= '0;
            pll_output_ratio <= '0;
        end else begin
            pll_ref_tick <= ref_sel ? osc_22m_tick : xtal_main_tick;
            pll_power_down <= pll_control[`PCSD_PLL_PD_BIT]
                              | system_power_down_enable;
            pll_bypass <= pll_control[`PCSD_PLL_BP_BIT];
            input_divide_ratio <= {1'b0, in_field}
                                  + 6'(`PCSD_PLL_RATIO_OFS);
            feedback_divide_ratio <= {1'b0, fb_field}
                                     + 10'(`PCSD_PLL_RATIO_OFS);
            pll_output_ratio <= out_ratio(
                pll_control[`PCSD_PLL_OUT_LSB +: 2]);
        end
    end

    // Powered-down core gives nothing; bypass still passes the reference
    always_ff @(posedge clk) begin
        if (reset) begin
            pll_out_tick <= 1'b0;
        end else if (gate_low) begin
            pll_out_tick <= 1'b0;
        end else if (pll_bypass) begin
            pll_out_tick <= pll_ref_tick;
        end else begin
            pll_out_tick <= pll_core_tick & ~pll_power_down;
        end
    end

    // Core bus clock and USB clock dividers
    pcsd_tick_div #(.W(4)) u_hclk_div (
        .clk(clk),
        .reset(reset),
        .tick_in(hclk_source_tick),
        .div(clock_divide_numbers[`PCSD_HCLK_N_LSB +: 4]),
        .tick_out(hclk_tick)
    );

    pcsd_tick_div #(.W(4)) u_usb_div (
        .clk(clk),
        .reset(reset),
        .tick_in(pll_out_tick),
        .div(clock_divide_numbers[`PCSD_USB_N_LSB +: 4]),
        .tick_out(usb_tick)
    );

    // Source vectors, index is the select code
    logic [3:0] src_common;
    logic [3:0] src_pll;
    logic [3:0] src_audio;
    logic [3:0] src_wdt;
    logic [7:0] sel_pwm;

    assign src_common = {osc_22m_tick, hclk_tick, xtal_32k_tick,
                         xtal_main_tick};
    assign src_pll = {osc_22m_tick, osc_22m_tick, pll_out_tick,
                      xtal_main_tick};
    assign src_audio = {osc_22m_tick, hclk_tick, pll_out_tick,
                        xtal_main_tick};
    // Codes 01 and 10 give no clock
    assign src_wdt = {osc_10k_tick, 1'b0, 1'b0, xtal_main_tick};
    assign sel_pwm = {peripheral_clock_source_select_b[`PCSD_PWM_D_LSB +: 2],
                      peripheral_clock_source_select_b[`PCSD_PWM_C_LSB +: 2],
                      peripheral_clock_source_select_a[`PCSD_PWM_B_LSB +: 2],
                      peripheral_clock_source_select_a[`PCSD_PWM_A_LSB +: 2]};

    for (genvar i = 0; i < 4; i++) begin : g_pwm
        pcsd_src_mux #(.SEL_W(2)) u_mux (
            .clk(clk),
            .reset(reset),
            .src(src_common),
            .sel(sel_pwm[2*i +: 2]),
            .tick(pwm_pair_engine_tick[i])
        );
    end

    for (genvar i = 0; i < 4; i++) begin : g_tmr
        logic [7:0] src_tmr;
        assign src_tmr = {{4{osc_22m_tick}}, timer_ext_trigger[i],
                          hclk_tick, xtal_32k_tick, xtal_main_tick};
        pcsd_src_mux #(.SEL_W(3)) u_mux (
            .clk(clk),
            .reset(reset),
            .src(src_tmr),
            .sel(peripheral_clock_source_select_a[
                `PCSD_TMR_A_LSB + `PCSD_TMR_STRIDE*i +: 3]),
            .tick(timer_engine_tick[i])
        );
    end

    pcsd_src_mux #(.SEL_W(2)) u_wdt_mux (
        .clk(clk),
        .reset(reset),
        .src(src_wdt),
        .sel(peripheral_clock_source_select_a[`PCSD_WDT_SEL_LSB +: 2]),
        .tick(watchdog_engine_tick)
    );

    pcsd_src_mux #(.SEL_W(2)) u_frq_mux (
        .clk(clk),
        .reset(reset),
        .src(src_common),
        .sel(peripheral_clock_source_select_b[`PCSD_FRQ_SEL_LSB +: 2]),
        .tick(freq_divider_engine_tick)
    );

    pcsd_src_mux #(.SEL_W(2)) u_aud_mux (
        .clk(clk),
        .reset(reset),
        .src(src_audio),
        .sel(peripheral_clock_source_select_b[`PCSD_AUD_SEL_LSB +: 2]),
        .tick(audio_serial_engine_tick)
    );

    // Muxed sources feeding the serial port, converter and CAN dividers
    logic uart_src_tick;
    logic adc_src_tick;
    logic can_src_tick;

    pcsd_src_mux #(.SEL_W(2)) u_uart_mux (
        .clk(clk),
        .reset(reset),
        .src(src_pll),
        .sel(peripheral_clock_source_select_a[`PCSD_UART_SEL_LSB +: 2]),
        .tick(uart_src_tick)
    );

    pcsd_src_mux #(.SEL_W(2)) u_adc_mux (
        .clk(clk),
        .reset(reset),
        .src(src_pll),
        .sel(peripheral_clock_source_select_a[`PCSD_ADC_SEL_LSB +: 2]),
        .tick(adc_src_tick)
    );

    pcsd_src_mux #(.SEL_W(2)) u_can_mux (
        .clk(clk),
        .reset(reset),
        .src(src_pll),
        .sel(peripheral_clock_source_select_a[`PCSD_CAN_SEL_LSB +: 2]),
        .tick(can_src_tick)
    );

    pcsd_tick_div #(.W(4)) u_uart_div (
        .clk(clk),
        .reset(reset),
        .tick_in(uart_src_tick),
        .div(clock_divide_numbers[`PCSD_UART_N_LSB +: 4]),
        .tick_out(uart_engine_tick)
    );

    pcsd_tick_div #(.W(8)) u_adc_div (
        .clk(clk),
        .reset(reset),
        .tick_in(adc_src_tick),
        .div(clock_divide_numbers[`PCSD_ADC_N_LSB +: 8]),
        .tick_out(adc_engine_tick)
    );

    // High part above a four-bit low part is sixteen times the high part
    logic [9:0] can_div;
    assign can_div = {clock_divide_numbers[`PCSD_CAN_NH_LSB +: 6],
                      clock_divide_numbers[`PCSD_CAN_NL_LSB +: 4]};

    pcsd_tick_div #(.W(10)) u_can_div (
        .clk(clk),
        .reset(reset),
        .tick_in(can_src_tick),
        .div(can_div),
        .tick_out(can_engine_tick)
    );

endmodule

`default_nettype wire

// ===== rtl/pcsd_defs.svh
`ifndef PCSD_DEFS_SVH
`define PCSD_DEFS_SVH

// Register offsets (byte addresses)
`define PCSD_ADDR_W 8
`define PCSD_OFF_SEL_A 8'h14
`define PCSD_OFF_DIV 8'h18
`define PCSD_OFF_SEL_B 8'h1C
`define PCSD_OFF_PLL 8'h20

// Reset values
`define PCSD_RST_SEL_A 32'hFFFFFFFF
`define PCSD_RST_DIV 32'h00000000
`define PCSD_RST_SEL_B 32'h000000F0
`define PCSD_RST_PLL 32'h0005C22E

// Writable bits; the rest read back as their reset value
`define PCSD_WMASK_SEL_A 32'hFF77770C
`define PCSD_WMASK_WDT 32'h00000003
`define PCSD_WMASK_DIV 32'h3FFFFFFF
`define PCSD_WMASK_SEL_B 32'h000000FF
`define PCSD_WMASK_PLL 32'h000FFFFF

// First select register fields
`define PCSD_PWM_B_LSB 30
`define PCSD_PWM_A_LSB 28
`define PCSD_CAN_SEL_LSB 26
`define PCSD_UART_SEL_LSB 24
`define PCSD_TMR_A_LSB 8
`define PCSD_TMR_STRIDE 4
`define PCSD_ADC_SEL_LSB 2
`define PCSD_WDT_SEL_LSB 0

// Second select register fields
`define PCSD_PWM_D_LSB 6
`define PCSD_PWM_C_LSB 4
`define PCSD_FRQ_SEL_LSB 2
`define PCSD_AUD_SEL_LSB 0

// Divide register fields
`define PCSD_HCLK_N_LSB 0
`define PCSD_USB_N_LSB 4
`define PCSD_UART_N_LSB 8
`define PCSD_CAN_NL_LSB 12
`define PCSD_ADC_N_LSB 16
`define PCSD_CAN_NH_LSB 24

// PLL control fields
`define PCSD_PLL_FB_LSB 0
`define PCSD_PLL_IN_LSB 9
`define PCSD_PLL_OUT_LSB 14
`define PCSD_PLL_PD_BIT 16
`define PCSD_PLL_BP_BIT 17
`define PCSD_PLL_OE_BIT 18
`define PCSD_PLL_REFERENCE_SELECT_BIT 19
`define PCSD_PLL_RATIO_OFS 2

`endif

// ===== rtl/pcsd_pkg.sv
package pcsd_pkg;

    typedef logic [31:0] pcsd_word_t;

    typedef enum logic [1:0] {
        PCSD_RUN,
        PCSD_WAIT_OLD,
        PCSD_WAIT_NEW
    } pcsd_sw_state_t;

endpackage

// ===== rtl/pcsd_src_mux.sv
`timescale 1ns/1ps
`default_nettype none

module pcsd_src_mux
    import pcsd_pkg::*;
#(
    parameter int SEL_W = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [(1 << SEL_W)-1:0] src,
    input wire logic [SEL_W-1:0] sel,
    output logic tick
);

    if (SEL_W < 1 || SEL_W > 3) begin : g_bad_width
        $error("pcsd_src_mux: SEL_W must be 1 to 3");
    end

    pcsd_sw_state_t state;
    logic [SEL_W-1:0] cur_sel;
    logic [SEL_W-1:0] pend_sel;

    // Finish the old period, then drop the first new tick so that the
    // gap across the switch is at least one full period of the new source
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= PCSD_RUN;
            cur_sel <= sel;
            pend_sel <= sel;
            tick <= 1'b0;
        end else begin
            unique case (state)
                PCSD_RUN: begin
                    tick <= src[cur_sel];
                    if (sel != cur_sel) begin
                        pend_sel <= sel;
                        state <= PCSD_WAIT_OLD;
                    end
                end
                PCSD_WAIT_OLD: begin
                    tick <= src[cur_sel];
                    if (src[cur_sel]) begin
                        cur_sel <= pend_sel;
                        state <= PCSD_WAIT_NEW;
                    end
                end
                PCSD_WAIT_NEW: begin
                    tick <= 1'b0;
                    if (src[cur_sel]) begin
                        state <= PCSD_RUN;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== rtl/pcsd_tick_div.sv
`timescale 1ns/1ps
`default_nettype none

module pcsd_tick_div #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tick_in,
    input wire logic [W-1:0] div,
    output logic tick_out
);

    if (W < 1 || W > 16) begin : g_bad_width
        $error("pcsd_tick_div: W must be 1 to 16");
    end

    logic [W-1:0] count;
    logic [W-1:0] cur_div;

    // A new ratio is taken only at terminal count, so no short period
    always_ff @(posedge clk) begin
        if (reset) begin
            count <= '0;
            cur_div <= '0;
            tick_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (count == cur_div) begin
                    count <= '0;
                    cur_div <= div;
                    tick_out <= 1'b1;
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/pcsd_clock_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none

module pcsd_clock_ctrl_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic system_power_down_enable,
    input wire logic xtal_main_tick,
    input wire logic osc_22m_tick,
    input wire logic osc_10k_tick,
    input wire logic hclk_source_tick,
    input wire logic hclk_tick,
    input wire logic usb_tick,
    input wire logic watchdog_engine_tick,
    input wire logic pll_ref_tick,
    input wire logic pll_out_tick,
    input wire logic pll_power_down,
    input wire logic pll_bypass,
    input wire logic [5:0] input_divide_ratio,
    input wire logic [9:0] feedback_divide_ratio,
    input wire logic [2:0] pll_output_ratio
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_pd_forced: assert property (
        $past(system_power_down_enable) |-> pll_power_down)
        else $error("system power-down did not stop the PLL");
    a_ratio_legal: assert property (!$past(reset) |->
        pll_output_ratio inside {3'h1, 3'h2, 3'h4} &&
        input_divide_ratio inside {[6'h02:6'h21]} &&
        feedback_divide_ratio inside {[10'h002:10'h201]})
        else $error("PLL ratio outside its legal set");
    a_pll_off_quiet: assert property (
        pll_power_down && $past(pll_power_down) && !pll_bypass &&
        !$past(pll_bypass) |-> !pll_out_tick)
        else $error("PLL output ticked while powered down");
    a_bypass_ref: assert property (
        pll_out_tick && pll_bypass && $past(pll_bypass)
        |-> $past(pll_ref_tick))
        else $error("bypassed PLL output not from reference");
    a_ref_source: assert property (
        pll_ref_tick |-> $past(xtal_main_tick) || $past(osc_22m_tick))
        else $error("PLL reference tick without a source tick");
    a_usb_from_pll: assert property (usb_tick |-> $past(pll_out_tick))
        else $error("USB tick without a PLL output tick");
    a_hclk_from_src: assert property (
        hclk_tick |-> $past(hclk_source_tick))
        else $error("bus clock tick without a source tick");
    a_wdt_source: assert property (
        watchdog_engine_tick |-> $past(xtal_main_tick) ||
        $past(osc_10k_tick))
        else $error("watchdog tick from an illegal source");

    c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
    c_bypass: cover property (pll_bypass && pll_out_tick);
    c_sys_pd: cover property (system_power_down_enable ##2 pll_power_down);
endmodule

bind pcsd_clock_ctrl pcsd_clock_ctrl_chk u_chk (
    .clk(clk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .system_power_down_enable(system_power_down_enable),
    .xtal_main_tick(xtal_main_tick), .osc_22m_tick(osc_22m_tick),
    .osc_10k_tick(osc_10k_tick), .hclk_source_tick(hclk_source_tick),
    .hclk_tick(hclk_tick), .usb_tick(usb_tick),
    .watchdog_engine_tick(watchdog_engine_tick),
    .pll_ref_tick(pll_ref_tick), .pll_out_tick(pll_out_tick),
    .pll_power_down(pll_power_down), .pll_bypass(pll_bypass),
    .input_divide_ratio(input_divide_ratio),
    .feedback_divide_ratio(feedback_divide_ratio),
    .pll_output_ratio(pll_output_ratio));

`default_nettype wire

// ===== tb/pcsd_clock_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcsd_defs.svh"

module pcsd_clock_ctrl_tb
    import pcsd_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    pcsd_word_t reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic unlocked = 1'b0;
    logic spde = 1'b0;
    logic x_t = 1'b0, k_t = 1'b0, o_t = 1'b0, t_t = 1'b0;
    logic s_t = 1'b0, p_t = 1'b0;
    logic [3:0] ext_t = 4'h0;
    logic hclk_tick, usb_tick, uart_t, adc_t, can_t, wdt_t, frq_t, aud_t;
    logic pll_ref_tick, pll_out_tick, pll_power_down, pll_bypass;
    logic [3:0] pwm_t, tmr_t;
    logic [5:0] input_divide_ratio;
    logic [9:0] feedback_divide_ratio;
    logic [2:0] pll_output_ratio;
    logic [17:0] outs;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] offs [4] = '{8'h14, 8'h18, 8'h1C, 8'h20};
    pcsd_word_t rstv [4] = '{`PCSD_RST_SEL_A, `PCSD_RST_DIV,
                             `PCSD_RST_SEL_B, `PCSD_RST_PLL};
    pcsd_word_t msk [4] = '{`PCSD_WMASK_SEL_A & ~`PCSD_WMASK_WDT,
                            `PCSD_WMASK_DIV, `PCSD_WMASK_SEL_B,
                            `PCSD_WMASK_PLL};
    pcsd_word_t cfg [3][3] = '{'{32'h1432140B, 32'h01041321, 32'h000000B5},
                               '{32'hB9032104, 32'h00010100, 32'h0000001A},
                               '{32'h42710033, 32'h00002012, 32'h000000C3}};
    int exp_p [3][16] = '{
        '{11, 3, 2, 10, 2, 11, 10, 17, 10, 21, 12, 10, 126, 13, 11, 7},
        '{2, 5, 11, 3, 11, 5, 17, 3, 5, 7, 14, 14, 2, 3, 5, 5},
        '{3, 11, 3, 2, 3, 3, 11, 2, 15, 14, 2, 3, 9, 13, 3, 2}};

    assign outs = {pll_ref_tick, pll_out_tick, aud_t, frq_t, wdt_t, can_t,
                   adc_t, uart_t, usb_tick, hclk_tick, tmr_t, pwm_t};

    always #12.5 clk = ~clk;

    // Every source keeps running, so a select may change at any time
    always @(posedge clk) begin
        cyc <= cyc + 1;
        x_t <= (cyc % 3 == 0);
        k_t <= (cyc % 11 == 0);
        o_t <= (cyc % 2 == 0);
        t_t <= (cyc % 13 == 0);
        s_t <= (cyc % 5 == 0);
        p_t <= (cyc % 7 == 0);
        ext_t <= {4{cyc % 17 == 0}};
    end

    pcsd_clock_ctrl u_dut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .write_protect_unlocked(unlocked),
        .system_power_down_enable(spde), .xtal_main_tick(x_t),
        .xtal_32k_tick(k_t), .osc_22m_tick(o_t), .osc_10k_tick(t_t),
        .hclk_source_tick(s_t), .pll_core_tick(p_t),
        .timer_ext_trigger(ext_t), .hclk_tick(hclk_tick),
        .usb_tick(usb_tick), .uart_engine_tick(uart_t),
        .adc_engine_tick(adc_t), .can_engine_tick(can_t),
        .pwm_pair_engine_tick(pwm_t), .timer_engine_tick(tmr_t),
        .watchdog_engine_tick(wdt_t), .freq_divider_engine_tick(frq_t),
        .audio_serial_engine_tick(aud_t), .pll_ref_tick(pll_ref_tick),
        .pll_out_tick(pll_out_tick), .pll_power_down(pll_power_down),
        .pll_bypass(pll_bypass), .input_divide_ratio(input_divide_ratio),
        .feedback_divide_ratio(feedback_divide_ratio),
        .pll_output_ratio(pll_output_ratio));

    task automatic check(input string nm, input pcsd_word_t seen,
                         input pcsd_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input pcsd_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input pcsd_word_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), reg_rdata, exp);
    endtask

    // Interval between the third and fourth tick, so the switch-over
    // and the old ratio's last count are not measured; 0 if no tick
    task automatic measure(input int idx, output int p);
        int n, last, c;
        n = 0;
        last = 0;
        c = 0;
        p = 0;
        while (n < 4 && c < 3000) begin
            @(posedge clk);
            #1;
            c++;
            if (outs[idx] === 1'b1) begin
                n++;
                p = c - last;
                last = c;
            end
        end
    endtask

    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #(40000 * 25);
        num_errors++;
        test_done;
    end

    initial begin
        int p;
        int c;
        string nm;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) rd(offs[i], rstv[i]);
        rd(8'h24, 32'h0);
        $display("test reset_values done");
        for (int i = 0; i < 4; i++) begin
            wr(offs[i], 32'h0);
            rd(offs[i], rstv[i] & ~msk[i]);
            wr(offs[i], 32'hFFFFFFFF);
            rd(offs[i], rstv[i] | msk[i]);
        end
        wr(8'h24, 32'hFFFFFFFF);
        rd(8'h24, 32'h0);
        // Reset again so the huge ratios just written do not stall counts
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(8'h20, `PCSD_RST_PLL);
        $display("test access_masks done");
        for (c = 0; c < 4; c++) begin
            wr(8'h20, 32'h00010000 | (c << 14) | ((c * 9 + 1) << 9) |
                      (c * 150 + 3));
            repeat (2) @(posedge clk);
            #1;
            check("in ratio", 32'(input_divide_ratio), c * 9 + 3);
            check("fb ratio", 32'(feedback_divide_ratio), c*150 + 5);
            check("out ratio", 32'(pll_output_ratio),
                  c == 0 ? 1 : (c == 3 ? 4 : 2));
            check("pd", 32'(pll_power_down), 1);
        end
        wr(8'h20, 32'h0000C22E);
        repeat (2) @(posedge clk);
        #1;
        check("pd", 32'(pll_power_down), 0);
        spde <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("pd", 32'(pll_power_down), 1);
        spde <= 1'b0;
        wr(8'h20, 32'h0002C22E);
        measure(16, p);
        check("bypass xtal", p, 3);
        check("bypass", 32'(pll_bypass), 1);
        wr(8'h20, 32'h000AC22E);
        measure(16, p);
        check("bypass osc", p, 2);
        measure(17, p);
        check("ref osc", p, 2);
        wr(8'h20, 32'h0006C22E);
        measure(16, p);
        check("gated", p, 0);
        wr(8'h20, 32'h0000C22E);
        $display("test pll_control done");
        for (int k = 0; k < 3; k++) begin
            if (k == 1) unlocked <= 1'b1;
            wr(8'h14, cfg[k][0]);
            wr(8'h18, cfg[k][1]);
            wr(8'h1C, cfg[k][2]);
            for (int i = 0; i < 16; i++) begin
                measure(i, p);
                nm = $sformatf("period %0d", i);
                if (i < 8)
                    check(nm, p, exp_p[k][i]);
                else if (i < 12)
                    check(nm, p, exp_p[k][i]);
                else
                    check(nm, p, exp_p[k][i]);
            end
            $display("test source_config %0d done", k);
        end
        test_done;
    end
endmodule

`default_nettype wire
